// ### logic/fdp_defs.svh
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH

// ==========================================================
// Widths and depths
`define FDP_WORD_W       10
`define FDP_WORD_MSB     9
`define FDP_FIFO_DEPTH   16
`define FDP_RX_DIV_W     4

// ==========================================================
// Timing: master clock and emulated input clock, in MHz
`define FDP_MCLK_MHZ     200
`define FDP_INCLK_MHZ    25
// Master cycles per half period of the input clock (rounded down)
`define FDP_TICK_DIV     (`FDP_MCLK_MHZ / (2 * `FDP_INCLK_MHZ))

// ==========================================================
// Reset values and encodings
`define FDP_PLL_MULT_2X  3'h2
`define FDP_PLL_MULT_4X  3'h4
`define FDP_MULT_RESET   3'h2

`endif

// ### logic/fdp_pkg.sv
`include "fdp_defs.svh"

package fdp_pkg;

    // ==========================================================
    // Interface modes
    typedef enum logic [1:0] {
        FDP_FD,
        FDP_SINGLE_BUS_HALF_DUPLEX,
        FDP_DUAL_BUS_HALF_DUPLEX,
        FDP_LEGACY
    } fdp_mode_type;

    // One sample of both channels
    typedef struct packed {
        logic [`FDP_WORD_W-1:0] ch2;
        logic [`FDP_WORD_W-1:0] ch1;
    } fdp_pair_type;

    // Latched configuration
    typedef struct packed {
        fdp_mode_type mode;
        logic         interp_4x;
        logic         pll_bypass;
        logic         serial;
    } fdp_cfg_type;

endpackage

// ### logic/fdp_port.sv
`include "fdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Receive sample FIFO
module fdp_fifo import fdp_pkg::*; #(
    parameter int WIDTH = 2 * `FDP_WORD_W,
    parameter int DEPTH = `FDP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = cnt_q != '0;
    assign out_data  = mem[rd_q];
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // Storage has no reset; only the pointers matter
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers, count and a registered ready
    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_q     <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q     <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q    <= cnt_d;
            in_ready <= cnt_d != (AW+1)'(DEPTH);
        end
    end
endmodule

module fdp_port import fdp_pkg::*; #(
    parameter int TICK_DIV = `FDP_TICK_DIV,
    parameter int DEPTH    = `FDP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     srst,
    // Straps and control pins
    input  wire logic                     active_low_reset_n,
    input  wire logic                     duplex_select,
    input  wire logic                     interp_select_4x,
    input  wire logic                     receive_power_down,
    input  wire logic                     transmit_power_down,
    // Serial configuration values
    input  wire logic                     serial_cfg_en,
    input  wire fdp_mode_type             serial_mode,
    input  wire logic                     serial_interp_4x,
    input  wire logic                     serial_pll_bypass,
    input  wire logic [`FDP_RX_DIV_W-1:0] rx_clk_div,
    // Interface pins
    input  wire logic                     interface_pin_one,
    input  wire logic                     interface_pin_two_in,
    output logic                          interface_pin_two_out,
    output logic                          interface_pin_two_oe_n,
    output logic                          interface_pin_three,
    // Data buses
    input  wire logic [`FDP_WORD_W-1:0]   upper_data_bus_in,
    output logic      [`FDP_WORD_W-1:0]   upper_data_bus_out,
    output logic      [`FDP_WORD_W-1:0]   upper_data_bus_oe_n,
    input  wire logic [`FDP_WORD_W-1:0]   lower_data_bus_in,
    output logic      [`FDP_WORD_W-1:0]   lower_data_bus_out,
    output logic      [`FDP_WORD_W-1:0]   lower_data_bus_oe_n,
    // Receive converter samples in
    input  wire fdp_pair_type             rx_pair,
    input  wire logic                     rx_valid,
    output logic                          rx_ready,
    // Transmit converter samples out
    output fdp_pair_type                  tx_pair_q,
    output logic                          tx_valid_q,
    // Status
    output fdp_cfg_type                   cfg_q,
    output logic [2:0]                    pll_mult_q,
    output logic                          rx_underrun_q
);
    localparam int PW = 7 + 2 * `FDP_WORD_W;

    // ==========================================================
    // Pin synchronisers
    logic [PW-1:0] pin_meta_q;
    logic [PW-1:0] pin_sync_q;
    logic          rstn_s;
    logic          dup_s;
    logic          i4x_s;
    logic          rxpd_s;
    logic          txpd_s;
    logic          pin1_s;
    logic          pin2_s;
    logic [`FDP_WORD_W-1:0] upper_s;
    logic [`FDP_WORD_W-1:0] lower_s;
    logic          rstn_q;

    // Every pin is asynchronous to mclk, so all pass two flops
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            rstn_q     <= 1'b0;
        end else begin
            pin_meta_q <= {active_low_reset_n, duplex_select, interp_select_4x, receive_power_down,
                           transmit_power_down, interface_pin_one, interface_pin_two_in,
                           upper_data_bus_in, lower_data_bus_in};
            pin_sync_q <= pin_meta_q;
            rstn_q     <= rstn_s;
        end
    end
    assign {rstn_s, dup_s, i4x_s, rxpd_s, txpd_s, pin1_s, pin2_s, upper_s, lower_s} = pin_sync_q;

    // ==========================================================
    // Configuration latch
    logic rstn_rise;
    assign rstn_rise = rstn_s && !rstn_q;

    // Straps are caught only on the reset release edge
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q      <= '{mode: FDP_FD, interp_4x: 1'b0, pll_bypass: 1'b0, serial: 1'b0};
            pll_mult_q <= `FDP_MULT_RESET;
        end else if (rstn_rise) begin
            if (serial_cfg_en) begin
                cfg_q.mode       <= serial_mode;
                cfg_q.interp_4x  <= serial_interp_4x;
                cfg_q.pll_bypass <= serial_pll_bypass;
                cfg_q.serial     <= 1'b1;
                pll_mult_q <= serial_interp_4x ? `FDP_PLL_MULT_4X : `FDP_PLL_MULT_2X;
            end else begin
                // Pin two carries the bus-width strap while straps are used
                cfg_q.mode       <= dup_s ? FDP_FD : (pin2_s ? FDP_SINGLE_BUS_HALF_DUPLEX : FDP_DUAL_BUS_HALF_DUPLEX);
                cfg_q.interp_4x  <= i4x_s;
                cfg_q.pll_bypass <= 1'b0;
                cfg_q.serial     <= 1'b0;
                pll_mult_q <= i4x_s ? `FDP_PLL_MULT_4X : `FDP_PLL_MULT_2X;
            end
        end
    end

    logic mode_fd;
    logic mode_single_bus_half_duplex;
    logic tx_inter;
    logic rx_inter;
    logic tx_dir;
    logic rx_act;
    logic tx_act;
    assign mode_fd   = cfg_q.mode == FDP_FD;
    assign mode_single_bus_half_duplex = cfg_q.mode == FDP_SINGLE_BUS_HALF_DUPLEX;
    assign tx_inter  = cfg_q.mode != FDP_DUAL_BUS_HALF_DUPLEX;
    assign rx_inter  = mode_fd || mode_single_bus_half_duplex;
    assign tx_dir    = !mode_fd && pin1_s;
    // Power downs act on their own path only
    assign rx_act    = rstn_s && !rxpd_s && (mode_fd || !tx_dir);
    assign tx_act    = rstn_s && !txpd_s && (mode_fd || tx_dir);

    // ==========================================================
    // Input clock emulation: one tick per half period
    logic [7:0] cnt_q;
    logic       tick;
    logic       mid;
    logic       in_phase_q;
    logic       in_phase_d;
    assign tick       = cnt_q == 8'(TICK_DIV - 1);
    assign mid        = cnt_q == 8'(TICK_DIV / 2 - 1);
    assign in_phase_d = tick ? !in_phase_q : in_phase_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q      <= '0;
            in_phase_q <= 1'b0;
        end else begin
            cnt_q      <= tick ? 8'h00 : 8'(cnt_q + 1'b1);
            in_phase_q <= in_phase_d;
        end
    end

    // Interleaved transmit clock rises every tick, falls mid-tick; needs TICK_DIV of two or more
    logic txclk_d;
    always_comb begin
        txclk_d = 1'b0;
        if (tx_act) begin
            if (tx_inter) begin
                txclk_d = tick ? 1'b1 : (mid ? 1'b0 : interface_pin_three);
            end else begin
                txclk_d = in_phase_d;
            end
        end
    end

    // ==========================================================
    // Receive divider and receive clock
    logic [`FDP_RX_DIV_W-1:0] div_q;
    logic rx_step;
    logic rx_rise;
    logic rx_phase_q;
    logic rx_phase_d;
    assign rx_step    = tick && div_q == rx_clk_div;
    assign rx_rise    = rx_step && !rx_phase_q;
    assign rx_phase_d = rx_step ? !rx_phase_q : rx_phase_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= (div_q == rx_clk_div) ? '0 : `FDP_RX_DIV_W'(div_q + 1'b1);
        end
    end

    // ==========================================================
    // Receive buffer
    fdp_pair_type f_data;
    logic         f_valid;
    logic         pop;
    assign pop = rx_rise && rx_act && f_valid;

    fdp_fifo #(.WIDTH(2 * `FDP_WORD_W), .DEPTH(DEPTH)) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_data   (rx_pair),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (pop)
    );

    // ==========================================================
    // Receive words; updated on the same edge as the receive clock
    fdp_pair_type hold_q;
    fdp_pair_type newp;
    assign newp = pop ? f_data : hold_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_phase_q         <= 1'b0;
            hold_q             <= '0;
            lower_data_bus_out <= '0;
            upper_data_bus_out <= '0;
            rx_underrun_q      <= 1'b0;
        end else if (rx_step) begin
            rx_phase_q <= !rx_phase_q;
            if (rx_rise) begin
                hold_q             <= newp;
                lower_data_bus_out <= newp.ch1;
                // Parallel modes put channel two on the upper bus
                upper_data_bus_out <= rx_inter ? {1'b1, 9'h000} : newp.ch2;
                if (rx_act && !f_valid) begin
                    rx_underrun_q <= 1'b1;
                end
            end else begin
                // Second word of the cycle; parallel modes simply hold
                lower_data_bus_out <= rx_inter ? hold_q.ch2 : hold_q.ch1;
                upper_data_bus_out <= rx_inter ? '0 : hold_q.ch2;
            end
        end
    end

    // ==========================================================
    // Clock pins and bus enables
    always_ff @(posedge mclk) begin
        if (srst) begin
            interface_pin_three    <= 1'b0;
            interface_pin_two_out  <= 1'b0;
            interface_pin_two_oe_n <= 1'b1;
            upper_data_bus_oe_n    <= '1;
            lower_data_bus_oe_n    <= '1;
        end else begin
            // Pin three: transmit clock in full duplex, else by direction
            interface_pin_three <= (mode_fd || tx_dir) ? txclk_d : (rx_act && rx_phase_d);
            // Pin two: system clock when serial, receive clock in full duplex, strap input otherwise
            interface_pin_two_out  <= cfg_q.serial ? in_phase_d : rx_phase_d;
            interface_pin_two_oe_n <= !(rstn_s && (cfg_q.serial || mode_fd));
            upper_data_bus_oe_n    <= '1;
            lower_data_bus_oe_n    <= '1;
            if (rstn_s) begin
                if (mode_fd) begin
                    lower_data_bus_oe_n <= '0;
                end else if (!tx_dir) begin
                    lower_data_bus_oe_n <= '0;
                    // Single-bus mode drives only the sync bit of the unused bus
                    upper_data_bus_oe_n <= mode_single_bus_half_duplex ? {1'b0, 9'h1ff} : '0;
                end
            end
        end
    end

    // ==========================================================
    // Transmit capture at each transmit clock rise: one word when interleaved, a word from each bus in dual-bus half duplex
    logic [`FDP_WORD_W-1:0] a_q;
    logic                   have_a_q;
    logic                   sync_bit;
    logic                   cap_il;
    logic                   cap_par;
    assign sync_bit = mode_fd ? pin1_s : lower_s[`FDP_WORD_MSB];
    assign cap_il   = tick && tx_act && tx_inter;
    assign cap_par  = tick && !in_phase_q && tx_act && !tx_inter;

    always_ff @(posedge mclk) begin
        if (srst) begin
            a_q        <= '0;
            have_a_q   <= 1'b0;
            tx_pair_q  <= '0;
            tx_valid_q <= 1'b0;
        end else begin
            tx_valid_q <= 1'b0;
            if (cap_il) begin
                if (sync_bit) begin
                    a_q      <= upper_s;
                    have_a_q <= 1'b1;
                end else if (have_a_q) begin
                    tx_pair_q  <= '{ch2: upper_s, ch1: a_q};
                    tx_valid_q <= 1'b1;
                    have_a_q   <= 1'b0;
                end
            end else if (cap_par) begin
                tx_pair_q  <= '{ch2: lower_s, ch1: upper_s};
                tx_valid_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_fd_upper_in;
        @(posedge mclk) disable iff (srst) (mode_fd ##1 mode_fd) |-> &upper_data_bus_oe_n;
    endproperty
    a_fd_upper_in: assert property (p_fd_upper_in) else $error("upper bus driven in full duplex");

    property p_txclk_rise;
        @(posedge mclk) disable iff (srst)
            (tick && tx_act && tx_inter && (mode_fd || tx_dir)) |=> interface_pin_three && !$past(interface_pin_three);
    endproperty
    a_txclk_rise: assert property (p_txclk_rise) else $error("transmit clock missed its rise");

    property p_fd_interleave;
        @(posedge mclk) disable iff (srst)
            mode_fd |-> lower_data_bus_out == (rx_phase_q ? hold_q.ch1 : hold_q.ch2);
    endproperty
    a_fd_interleave: assert property (p_fd_interleave) else $error("receive word mismatches clock level");

    property p_pair_done;
        @(posedge mclk) disable iff (srst)
            (cap_il && !sync_bit && have_a_q) |=> tx_valid_q && tx_pair_q.ch1 == $past(a_q);
    endproperty
    a_pair_done: assert property (p_pair_done) else $error("transmit pair not completed");

    property p_cfg_hold;
        @(posedge mclk) disable iff (srst) !rstn_rise |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed outside reset edge");

    property p_hd_dir_low;
        @(posedge mclk) disable iff (srst)
            (!mode_fd && !pin1_s && rstn_s) ##1 (!mode_fd && !pin1_s && rstn_s) |-> !lower_data_bus_oe_n[0] && !tx_valid_q;
    endproperty
    a_hd_dir_low: assert property (p_hd_dir_low) else $error("receive direction left pins undriven");

    property p_single_bus_half_duplex_tristate;
        @(posedge mclk) disable iff (srst)
            (mode_single_bus_half_duplex ##1 mode_single_bus_half_duplex) |-> &upper_data_bus_oe_n[`FDP_WORD_MSB-1:0] && (tx_dir ? &lower_data_bus_oe_n : 1'b1);
    endproperty
    a_single_bus_half_duplex_tristate: assert property (p_single_bus_half_duplex_tristate) else $error("unused bus not tri-stated");

    property p_sysclk;
        @(posedge mclk) disable iff (srst)
            (cfg_q.serial && rstn_s) ##1 (cfg_q.serial && rstn_s) |-> !interface_pin_two_oe_n;
    endproperty
    a_sysclk: assert property (p_sysclk) else $error("system clock not driven on pin two");

    property p_legacy_serial;
        @(posedge mclk) disable iff (srst) cfg_q.mode == FDP_LEGACY |-> cfg_q.serial;
    endproperty
    a_legacy_serial: assert property (p_legacy_serial) else $error("legacy mode without serial setup");

    property p_mult;
        @(posedge mclk) disable iff (srst)
            rstn_rise |=> pll_mult_q == (cfg_q.interp_4x ? `FDP_PLL_MULT_4X : `FDP_PLL_MULT_2X);
    endproperty
    a_mult: assert property (p_mult) else $error("PLL factor differs from interpolation");

    c_fd_pair: cover property (@(posedge mclk) disable iff (srst) mode_fd && tx_valid_q);
    c_single_bus_half_duplex_rx: cover property (@(posedge mclk) disable iff (srst) mode_single_bus_half_duplex && pop);
    c_dual_bus_half_duplex_tx: cover property (@(posedge mclk) disable iff (srst) cfg_q.mode == FDP_DUAL_BUS_HALF_DUPLEX && cap_par);
    c_fifo_full: cover property (@(posedge mclk) disable iff (srst) !rx_ready && rstn_s);
endmodule

`default_nettype wire

// ### sim/fdp_backend.sv
`include "fdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Back end model: launches interleaved transmit words, captures receive pairs
module fdp_backend import fdp_pkg::*; (
    // Clock and control
    input  wire logic                   mclk,
    input  wire logic                   tx_en,
    // Device clocks and receive bus
    input  wire logic                   rx_clk,
    input  wire logic                   tx_clk,
    input  wire logic                   rx_on,
    input  wire logic [`FDP_WORD_W-1:0] rx_bus,
    // Transmit bus and sync
    output logic      [`FDP_WORD_W-1:0] tx_bus = '0,
    output logic                        tx_sync = 1'b0
);
    fdp_pair_type           tx_q[$];
    fdp_pair_type           rx_q[$];
    fdp_pair_type           cur;
    logic                   prev_clk = 1'b0;
    logic [`FDP_WORD_W-1:0] prev_dat = '0;
    int                     seed     = 12;

    // One word per rising edge, ch1 first; idle bus keeps changing so no stale value passes
    always @(posedge tx_clk) begin
        #1;
        if (tx_en) begin
            tx_sync = ~tx_sync;
            tx_bus = (`FDP_WORD_W)'($random(seed));
            if (tx_sync) cur.ch1 = tx_bus;
            else begin
                cur.ch2 = tx_bus;
                tx_q.push_back(cur);
            end
        end else begin
            tx_sync = 1'b0;
            tx_bus = ~tx_bus;
        end
    end

    // At a fall of the receive clock: high phase held ch1, new low phase holds ch2
    always @(posedge mclk) begin
        if (prev_clk && !rx_clk && rx_on) rx_q.push_back({rx_bus, prev_dat});
        prev_clk <= rx_clk;
        prev_dat <= rx_bus;
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
`include "fdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the duplex data port
module tb import fdp_pkg::*; ;
    localparam int W = `FDP_WORD_W;
    logic mclk = 1'b0, srst = 1'b1, rst_pin_n = 1'b0, dup = 1'b1, i4x = 1'b0, rx_pd = 1'b1;
    logic ser_en = 1'b0, s_i4 = 1'b0, s_byp = 1'b0, dir = 1'b0, width = 1'b1, tx_en = 1'b0, rx_v = 1'b0;
    logic tx_pd = 1'b0, p2_prev = 1'b0;
    logic [`FDP_RX_DIV_W-1:0] rx_div = 4'h0;
    logic p2_out, p2_oe_n, p3, rx_rdy, tx_v, unr, p_sync, tx_chk = 1'b0;
    logic [W-1:0] up_out, up_oe_n, lo_out, lo_oe_n, p_bus, up_w, lo_w;
    fdp_mode_type s_mode = FDP_FD;
    fdp_pair_type rx_d = '0, tx_pair, exp_rx[$];
    fdp_cfg_type  cfg;
    logic [2:0]   mult;
    int fail_count = 0, samples_checked = 0, seed = 12, n, tx_cnt = 0, rx_rises = 0;
    logic [W-1:0] up_e[5] = '{10'h3ff, 10'h1ff, 10'h000, 10'h3ff, 10'h3ff};
    logic [W-1:0] lo_e[5] = '{10'h000, 10'h000, 10'h000, 10'h3ff, 10'h3ff};
    fdp_mode_type md_e[5] = '{FDP_FD, FDP_SINGLE_BUS_HALF_DUPLEX, FDP_DUAL_BUS_HALF_DUPLEX, FDP_LEGACY, FDP_SINGLE_BUS_HALF_DUPLEX};

    // Wire levels: undriven lower bus bits show the inverse of the lower bus output register
    assign up_w = (up_oe_n & p_bus) | (~up_oe_n & up_out);
    assign lo_w = lo_oe_n ^ lo_out;
    always #2.5 mclk = ~mclk;

    fdp_port fdp_port_inst (.mclk(mclk), .srst(srst), .active_low_reset_n(rst_pin_n), .duplex_select(dup),
        .interp_select_4x(i4x), .receive_power_down(rx_pd), .transmit_power_down(tx_pd), .serial_cfg_en(ser_en),
        .serial_mode(s_mode), .serial_interp_4x(s_i4), .serial_pll_bypass(s_byp), .rx_clk_div(rx_div),
        .interface_pin_one(tx_en ? p_sync : dir), .interface_pin_two_in(p2_oe_n ? width : p2_out),
        .interface_pin_two_out(p2_out), .interface_pin_two_oe_n(p2_oe_n), .interface_pin_three(p3),
        .upper_data_bus_in(up_w), .upper_data_bus_out(up_out), .upper_data_bus_oe_n(up_oe_n),
        .lower_data_bus_in(lo_w), .lower_data_bus_out(lo_out), .lower_data_bus_oe_n(lo_oe_n),
        .rx_pair(rx_d), .rx_valid(rx_v), .rx_ready(rx_rdy), .tx_pair_q(tx_pair), .tx_valid_q(tx_v),
        .cfg_q(cfg), .pll_mult_q(mult), .rx_underrun_q(unr));
    fdp_backend fdp_backend_inst (.mclk(mclk), .tx_en(tx_en), .rx_clk(p2_oe_n ? width : p2_out), .tx_clk(p3),
        .rx_on(!lo_oe_n[0]), .rx_bus(lo_w), .tx_bus(p_bus), .tx_sync(p_sync));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // Pulse the device reset pin so the straps are latched on its rising edge
    task automatic latch(input logic d, input logic w, input logic s);
        dup = d;
        width = w;
        ser_en = s;
        s_byp = s;
        s_i4 = i4x;
        rst_pin_n = 1'b0;
        step(4);
        rst_pin_n = 1'b1;
        step(8);
    endtask

    task automatic end_of_test;
        $display("samples_checked %0d fail_count %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Every transmit pair seen while tx_chk is set is compared against what the back end launched
    always @(posedge mclk) begin
        if (tx_chk && tx_v === 1'b1) begin
            tx_cnt++;
            chk(tx_pair, fdp_backend_inst.tx_q.size() ? fdp_backend_inst.tx_q.pop_front() : 'x, "tx pair");
        end
    end

    // Rising edges of the receive clock on pin two, for the divider check
    always @(posedge mclk) begin
        if (p2_out === 1'b1 && p2_prev === 1'b0) rx_rises++;
        p2_prev <= p2_out;
    end

    initial begin
        step(10);
        srst = 1'b0;
        i4x = 1'b1;
        latch(1'b1, 1'b1, 1'b0);
        chk(cfg.mode, FDP_FD, "full duplex strap");
        chk(mult, `FDP_PLL_MULT_4X, "pll factor 4x");
        chk(p2_oe_n, 1'b0, "receive clock pin driven");
        tx_en = 1'b1;
        tx_chk = 1'b1;
        // Fill while the receive path is powered down: nothing drains, so the buffer must refuse
        rx_v = 1'b1;
        rx_d = (2 * W)'($random(seed));
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            if (rx_rdy === 1'b1) begin
                exp_rx.push_back(rx_d);
                n++;
            end
            #1 rx_d = (2 * W)'($random(seed));
        end
        rx_v = 1'b0;
        chk(n, `FDP_FIFO_DEPTH, "buffer depth");
        chk(unr, 1'b0, "no underrun while powered down");
        // Pairs seen before power-up only repeat the idle hold register
        fdp_backend_inst.rx_q.delete();
        rx_pd = 1'b0;
        step(300);
        n = 0;
        // Words before the first pop are not data
        while (n < 4 && fdp_backend_inst.rx_q.size() > 0 && fdp_backend_inst.rx_q[0] !== exp_rx[0]) begin
            void'(fdp_backend_inst.rx_q.pop_front());
            n++;
        end
        foreach (exp_rx[i]) begin
            chk(i < fdp_backend_inst.rx_q.size() ? fdp_backend_inst.rx_q[i] : 'x, exp_rx[i], "rx pair");
        end
        chk(unr, 1'b1, "underrun once drained");
        chk(tx_cnt > 20, 1'b1, "transmit concurrent");
        tx_en = 1'b0;
        tx_chk = 1'b0;
        // Transmit powered down: its clock stops while the receive clock runs on a new divider
        tx_pd = 1'b1;
        rx_div = 4'h2;
        step(40);
        n = rx_rises;
        repeat (240) begin
            step(1);
            chk(p3, 1'b0, "transmit clock stopped");
        end
        chk(rx_rises - n, 240 / (2 * 3 * `FDP_TICK_DIV), "receive divider");
        tx_pd = 1'b0;
        // Strap and serial configurations with bus directions
        for (int k = 0; k < 5; k++) begin
            dir = k >= 3;
            i4x = k[0];
            s_mode = FDP_LEGACY;
            latch(k == 0, k != 2, k == 3);
            chk(cfg.mode, md_e[k], "latched mode");
            chk(mult, k[0] ? `FDP_PLL_MULT_4X : `FDP_PLL_MULT_2X, "pll factor");
            chk(cfg.pll_bypass, k == 3, "pll bypass");
            chk(up_oe_n, up_e[k], "upper direction");
            chk(lo_oe_n, lo_e[k], "lower direction");
            chk(p2_oe_n, k == 1 || k == 2 || k == 4, "pin two use");
        end
        dup = 1'b1;
        step(10);
        chk(cfg.mode, FDP_SINGLE_BUS_HALF_DUPLEX, "held until reset");
        end_of_test();
    end

    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
